// ===== rtl/cpc_control.sv
// Consumer digital output, 3D gain coding and peripheral pin control register bank
// Operation
// - Consumer enable switches output to IEC-958 format only with serial enable
// - Serial port runs only with serial enable
// - Restart bit resets channel status block boundary
// - User and validity bits in every sub-frame
// - Gain codes attenuate 1.5 dB per step
// - Status bit 1 from audio flag
// - Status bit 2 from copy flag
// - Status bits 4,3 carry emphasis field
// - Status bit 5 carries lock flag
// - Status bits 8,9 from lower register
// - Reset force drives peripheral reset low
// - Clock disable holds synth clock low
// - Port switch moves serial pins to periph
// - Periph pins serial only with serial enable
// - Switch or synth enable quiets host bus
// - Configuration byte can set both bits
// - Synth enable repurposes high periph pins
// - Synth enable swaps digital volume pairs
// - Mono mode forces center 0, space 2
// - 3D path and mono need enable
// - Output select picks converter or 3D data
`timescale 1ns/1ns
`default_nettype none

module cpc_control (
    // Clock and reset
    input wire logic CLK,
    input wire logic RST,
    // AXI4-Lite write address
    input wire logic [7:0] AWADDR,
    input wire logic AWVALID,
    output logic AWREADY,
    // AXI4-Lite write data
    input wire logic [31:0] WDATA,
    input wire logic [3:0] WSTRB,
    input wire logic WVALID,
    output logic WREADY,
    // AXI4-Lite write response
    output logic [1:0] BRESP,
    output logic BVALID,
    input wire logic BREADY,
    // AXI4-Lite read address
    input wire logic [7:0] ARADDR,
    input wire logic ARVALID,
    output logic ARREADY,
    // AXI4-Lite read data
    output logic [31:0] RDATA,
    output logic [1:0] RRESP,
    output logic RVALID,
    input wire logic RREADY,
    // Configuration data load from external memory
    input wire logic CFG_LOAD,
    input wire logic CFG_PORT_SWITCH,
    input wire logic CFG_SYNTH_ENABLE,
    // Audio frame timing and sample sources
    input wire logic FRAME_TICK,
    input wire logic CONVERTER_BIT,
    input wire logic SPATIAL_BIT,
    // Consumer output stream controls
    output logic SERIAL_RUN,
    output logic CONSUMER_FORMAT,
    output logic SUBFRAME_USER,
    output logic SUBFRAME_VALID,
    output logic SUBFRAME_STATUS,
    output logic BLOCK_START,
    output logic SERIAL_DATA_BIT,
    // Peripheral pins
    output logic PERIPH_RESET_N,
    output logic SYNTH_CLOCK_GATE,
    output logic [3:0] PERIPH_LOW_SERIAL_EN,
    output logic [2:0] PERIPH_HIGH_SYNTH_EN,
    output logic JOYSTICK_SERIAL_EN,
    output logic HOST_BUS_QUIET,
    output logic WAVE_VOLUME_SWAP,
    // 3D processing state
    output cpc_pkg::cpc_spatial_s SPATIAL
);

    // Stored registers
    logic [7:0] space_center;       // Space code high nibble, center code low nibble
    logic [7:0] spatial_ctrl;       // Enable, mono, output select
    logic [7:0] consumer_port;      // Enable, user, validity; restart is not stored
    logic [7:0] lower_status;       // Channel status bits 1..5, 8 and 9
    logic [7:0] upper_status;       // Upper category and frequency bits
    logic [7:0] wavetable_pin;      // Low four control bits
    logic [7:0] alt_feature;        // Serial port enable lives here

    // Write channel holding state
    logic aw_held;                  // Address captured, waiting for data
    logic w_held;                   // Data captured, waiting for address
    logic [7:0] aw_addr;            // Captured write address
    logic [31:0] w_data;            // Captured write data
    logic [3:0] w_strb;             // Captured strobes
    logic do_write;                 // Both halves present, commit next cycle
    logic commit;                   // Delayed write strobe

    // Channel status sequencing
    logic [7:0] frame_index;        // Position in the 191-frame block
    logic restart_req;              // Pending block restart

    // Channel status bit for a frame index; bits beyond the stored ones are zero
    function automatic logic status_bit(input logic [7:0] idx, input logic [7:0] lo,
                                        input logic [7:0] hi);
        logic r;
        r = 1'b0;
        if (idx >= 8'h01 && idx <= 8'h05)
            r = lo[idx[2:0]];
        else if (idx == 8'h08)
            r = lo[cpc_pkg::LCS_CAT8];
        else if (idx == 8'h09)
            r = lo[cpc_pkg::LCS_CAT9];
        else if (idx >= 8'h0A && idx <= 8'h0F)
            r = hi[idx[2:0] - 3'h2];
        return r;
    endfunction

    // Attenuation in tenths of dB for a gain code
    function automatic logic [7:0] atten(input logic [3:0] code);
        logic [11:0] p;
        p = {8'h00, code} * {4'h0, cpc_pkg::GAIN_STEP_TENTHS};
        return p[7:0];
    endfunction

    // Byte lane 0 merge under strobe, with reserved bits masked off
    function automatic logic [7:0] merge(input logic [7:0] old, input logic [31:0] d,
                                         input logic [3:0] s, input logic [7:0] m);
        logic [7:0] r;
        r = s[0] ? (d[7:0] & m) : old;
        return r;
    endfunction

    assign do_write = (aw_held || (AWVALID && AWREADY)) && (w_held || (WVALID && WREADY));

    // Write address capture; ready drops while a write is held or answered
    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            AWREADY <= 1'b0;
            aw_held <= 1'b0;
            aw_addr <= cpc_pkg::RESET_BYTE;
        end
        else
        begin
            AWREADY <= !aw_held && !BVALID && !(AWVALID && AWREADY) && !do_write && !commit;
            if (AWVALID && AWREADY)
                aw_addr <= AWADDR;
            if (do_write)
                aw_held <= 1'b0;
            else if (AWVALID && AWREADY)
                aw_held <= 1'b1;
        end
    end

    // Write data capture, independent of address order
    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            WREADY <= 1'b0;
            w_held <= 1'b0;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
        end
        else
        begin
            WREADY <= !w_held && !BVALID && !(WVALID && WREADY) && !do_write && !commit;
            if (WVALID && WREADY)
            begin
                w_data <= WDATA;
                w_strb <= WSTRB;
            end
            if (do_write)
                w_held <= 1'b0;
            else if (WVALID && WREADY)
                w_held <= 1'b1;
        end
    end

    // Register commit; a write lands one cycle after both halves are taken
    logic unmapped_w;               // Address outside the map
    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            commit <= 1'b0;
            BVALID <= 1'b0;
            BRESP <= cpc_pkg::RESP_OKAY;
        end
        else
        begin
            commit <= do_write;
            if (commit)
            begin
                BVALID <= 1'b1;
                BRESP <= unmapped_w ? cpc_pkg::RESP_SLVERR : cpc_pkg::RESP_OKAY;
            end
            else if (BVALID && BREADY)
                BVALID <= 1'b0;
        end
    end

    // Address decode of the pending write
    always_comb
    begin
        unmapped_w = 1'b1;
        case (aw_addr)
            cpc_pkg::ADDR_SPACE_CENTER, cpc_pkg::ADDR_SPATIAL_CTRL,
            cpc_pkg::ADDR_CONSUMER_PORT, cpc_pkg::ADDR_LOWER_STATUS,
            cpc_pkg::ADDR_UPPER_STATUS, cpc_pkg::ADDR_RESERVED_CTRL,
            cpc_pkg::ADDR_WAVETABLE_PIN, cpc_pkg::ADDR_ALT_FEATURE,
            cpc_pkg::ADDR_STATUS:
                unmapped_w = 1'b0;
            default:
                unmapped_w = 1'b1;
        endcase
    end

    // Software-writable registers; reserved bits are masked so they read zero
    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            space_center <= cpc_pkg::RESET_BYTE;
            spatial_ctrl <= cpc_pkg::RESET_BYTE;
            consumer_port <= cpc_pkg::RESET_BYTE;
            lower_status <= cpc_pkg::RESET_BYTE;
            upper_status <= cpc_pkg::RESET_BYTE;
            alt_feature <= cpc_pkg::RESET_BYTE;
        end
        else if (commit)
        begin
            // new value acts from the next cycle onward
            case (aw_addr)
                cpc_pkg::ADDR_SPACE_CENTER:
                    space_center <= merge(space_center, w_data, w_strb, 8'hFF);
                cpc_pkg::ADDR_SPATIAL_CTRL:
                    spatial_ctrl <= merge(spatial_ctrl, w_data, w_strb, cpc_pkg::SP_WRITE_MASK);
                cpc_pkg::ADDR_CONSUMER_PORT:
                    consumer_port <= merge(consumer_port, w_data, w_strb, 8'hB0);
                cpc_pkg::ADDR_LOWER_STATUS:
                    lower_status <= merge(lower_status, w_data, w_strb, cpc_pkg::LCS_WRITE_MASK);
                cpc_pkg::ADDR_UPPER_STATUS:
                    upper_status <= merge(upper_status, w_data, w_strb, 8'hFF);
                cpc_pkg::ADDR_ALT_FEATURE:
                    alt_feature <= merge(alt_feature, w_data, w_strb, 8'h01);
                default:
                    space_center <= space_center;
            endcase
        end
    end

    // Wavetable pin control: software write or configuration load may set bits
    always_ff @(posedge CLK)
    begin
        if (RST)
            wavetable_pin <= cpc_pkg::RESET_BYTE;
        else
        begin
            if (commit && aw_addr == cpc_pkg::ADDR_WAVETABLE_PIN)
                wavetable_pin <= merge(wavetable_pin, w_data, w_strb, cpc_pkg::WT_WRITE_MASK);
            if (CFG_LOAD)
            begin
                // configuration byte sets routing bits, load wins on a tie
                wavetable_pin[cpc_pkg::WT_PORT_SWITCH] <= CFG_PORT_SWITCH;
                wavetable_pin[cpc_pkg::WT_PORT_ENABLE] <= CFG_SYNTH_ENABLE;
            end
        end
    end

    // Block restart request: the restart bit is a write-one action, not stored
    always_ff @(posedge CLK)
    begin
        if (RST)
            restart_req <= 1'b0;
        else if (commit && aw_addr == cpc_pkg::ADDR_CONSUMER_PORT && w_strb[0]
                 && w_data[cpc_pkg::RESTART_BIT])
            restart_req <= 1'b1;
        else if (FRAME_TICK)
            restart_req <= 1'b0;
    end

    // Frame counter walks the status block; a restart sends bit 0 next
    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            frame_index <= cpc_pkg::RESET_BYTE;
            SUBFRAME_STATUS <= 1'b0;
            BLOCK_START <= 1'b0;
        end
        else if (FRAME_TICK)
        begin
            if (restart_req || frame_index == cpc_pkg::BLOCK_LAST)
            begin
                frame_index <= 8'h01;
                SUBFRAME_STATUS <= status_bit(8'h00, lower_status, upper_status);
                BLOCK_START <= 1'b1;
            end
            else
            begin
                frame_index <= frame_index + 8'h01;
                SUBFRAME_STATUS <= status_bit(frame_index, lower_status, upper_status);
                BLOCK_START <= 1'b0;
            end
        end
    end

    // Serial output controls and data source selection
    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            SERIAL_RUN <= 1'b0;
            CONSUMER_FORMAT <= 1'b0;
            SUBFRAME_USER <= 1'b0;
            SUBFRAME_VALID <= 1'b0;
            SERIAL_DATA_BIT <= 1'b0;
        end
        else
        begin
            SERIAL_RUN <= alt_feature[cpc_pkg::ALT_SERIAL_EN];
            CONSUMER_FORMAT <= consumer_port[cpc_pkg::CPE_BIT]
                               && alt_feature[cpc_pkg::ALT_SERIAL_EN];
            SUBFRAME_USER <= consumer_port[cpc_pkg::USER_BIT];
            SUBFRAME_VALID <= consumer_port[cpc_pkg::VALID_BIT];
            SERIAL_DATA_BIT <= spatial_ctrl[cpc_pkg::SP_OUT_SELECT] ? SPATIAL_BIT
                                                                    : CONVERTER_BIT;
        end
    end

    // Peripheral pin routing derived from the wavetable control bits
    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            PERIPH_RESET_N <= 1'b1;
            SYNTH_CLOCK_GATE <= 1'b1;
            PERIPH_LOW_SERIAL_EN <= 4'h0;
            PERIPH_HIGH_SYNTH_EN <= 3'h0;
            JOYSTICK_SERIAL_EN <= 1'b0;
            HOST_BUS_QUIET <= 1'b0;
            WAVE_VOLUME_SWAP <= 1'b0;
        end
        else
        begin
            PERIPH_RESET_N <= !wavetable_pin[cpc_pkg::WT_RESET_FORCE];
            SYNTH_CLOCK_GATE <= !wavetable_pin[cpc_pkg::WT_CLOCK_DISABLE];
            PERIPH_LOW_SERIAL_EN <= {4{wavetable_pin[cpc_pkg::WT_PORT_SWITCH]
                                       && alt_feature[cpc_pkg::ALT_SERIAL_EN]}};
            JOYSTICK_SERIAL_EN <= !wavetable_pin[cpc_pkg::WT_PORT_SWITCH]
                                  && alt_feature[cpc_pkg::ALT_SERIAL_EN];
            PERIPH_HIGH_SYNTH_EN <= {3{wavetable_pin[cpc_pkg::WT_PORT_ENABLE]}};
            HOST_BUS_QUIET <= wavetable_pin[cpc_pkg::WT_PORT_SWITCH]
                              || wavetable_pin[cpc_pkg::WT_PORT_ENABLE];
            WAVE_VOLUME_SWAP <= wavetable_pin[cpc_pkg::WT_PORT_ENABLE];
        end
    end

    // Spatial state: mono mode overrides gains and needs the enable
    always_ff @(posedge CLK)
    begin
        if (RST)
            SPATIAL <= '0;
        else
        begin
            SPATIAL.run <= spatial_ctrl[cpc_pkg::SP_ENABLE];
            SPATIAL.mono <= spatial_ctrl[cpc_pkg::SP_ENABLE]
                            && spatial_ctrl[cpc_pkg::SP_MONO];
            SPATIAL.out_from_spatial <= spatial_ctrl[cpc_pkg::SP_OUT_SELECT];
            if (spatial_ctrl[cpc_pkg::SP_ENABLE] && spatial_ctrl[cpc_pkg::SP_MONO])
            begin
                SPATIAL.space_code <= cpc_pkg::MONO_SPACE_CODE;
                SPATIAL.center_code <= cpc_pkg::MONO_CENTER_CODE;
                SPATIAL.space_atten <= atten(cpc_pkg::MONO_SPACE_CODE);
                SPATIAL.center_atten <= atten(cpc_pkg::MONO_CENTER_CODE);
            end
            else
            begin
                SPATIAL.space_code <= space_center[7:4];
                SPATIAL.center_code <= space_center[3:0];
                SPATIAL.space_atten <= atten(space_center[7:4]);
                SPATIAL.center_atten <= atten(space_center[3:0]);
            end
        end
    end

    // Read channel; reads only return data, nothing changes state
    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            ARREADY <= 1'b0;
            RVALID <= 1'b0;
            RDATA <= 32'h0000_0000;
            RRESP <= cpc_pkg::RESP_OKAY;
        end
        else
        begin
            ARREADY <= !RVALID && !(ARVALID && ARREADY);
            if (ARVALID && ARREADY)
            begin
                RVALID <= 1'b1;
                RRESP <= cpc_pkg::RESP_OKAY;
                case (ARADDR)
                    cpc_pkg::ADDR_SPACE_CENTER: RDATA <= {24'h000000, space_center};
                    cpc_pkg::ADDR_SPATIAL_CTRL: RDATA <= {24'h000000, spatial_ctrl};
                    cpc_pkg::ADDR_CONSUMER_PORT: RDATA <= {24'h000000, consumer_port};
                    cpc_pkg::ADDR_LOWER_STATUS: RDATA <= {24'h000000, lower_status};
                    cpc_pkg::ADDR_UPPER_STATUS: RDATA <= {24'h000000, upper_status};
                    cpc_pkg::ADDR_RESERVED_CTRL: RDATA <= 32'h0000_0000;
                    cpc_pkg::ADDR_WAVETABLE_PIN: RDATA <= {24'h000000, wavetable_pin};
                    cpc_pkg::ADDR_ALT_FEATURE: RDATA <= {24'h000000, alt_feature};
                    cpc_pkg::ADDR_STATUS: RDATA <= {24'h000000, frame_index};
                    default:
                    begin
                        RDATA <= 32'h0000_0000;
                        RRESP <= cpc_pkg::RESP_SLVERR;
                    end
                endcase
            end
            else if (RVALID && RREADY)
                RVALID <= 1'b0;
        end
    end

endmodule

`default_nettype wire

// ===== rtl/cpc_pkg.sv
// Package with register map, field positions and shared types for the consumer-out pin control
package cpc_pkg;

    // Byte addresses on the AXI4-Lite slave (one aligned word per register)
    localparam logic [7:0] ADDR_SPACE_CENTER = 8'h08;
    localparam logic [7:0] ADDR_SPATIAL_CTRL = 8'h0C;
    localparam logic [7:0] ADDR_CONSUMER_PORT = 8'h10;
    localparam logic [7:0] ADDR_LOWER_STATUS = 8'h14;
    localparam logic [7:0] ADDR_UPPER_STATUS = 8'h18;
    localparam logic [7:0] ADDR_RESERVED_CTRL = 8'h1C;
    localparam logic [7:0] ADDR_WAVETABLE_PIN = 8'h20;
    localparam logic [7:0] ADDR_ALT_FEATURE = 8'h24;
    localparam logic [7:0] ADDR_STATUS = 8'h28;

    // Consumer port enable control fields
    localparam int CPE_BIT = 7;
    localparam int RESTART_BIT = 6;
    localparam int USER_BIT = 5;
    localparam int VALID_BIT = 4;

    // Lower channel status fields (channel status bit positions in register)
    localparam int LCS_AUDIO = 1;
    localparam int LCS_COPY = 2;
    localparam int LCS_EMPH_LO = 3;
    localparam int LCS_EMPH_HI = 4;
    localparam int LCS_LOCK = 5;
    localparam int LCS_CAT8 = 6;
    localparam int LCS_CAT9 = 7;
    localparam logic [7:0] LCS_WRITE_MASK = 8'hFE;

    // Wavetable pin control fields
    localparam int WT_RESET_FORCE = 0;
    localparam int WT_CLOCK_DISABLE = 1;
    localparam int WT_PORT_SWITCH = 2;
    localparam int WT_PORT_ENABLE = 3;
    localparam logic [7:0] WT_WRITE_MASK = 8'h0F;

    // Spatial control fields
    localparam int SP_OUT_SELECT = 5;
    localparam int SP_MONO = 6;
    localparam int SP_ENABLE = 7;
    localparam logic [7:0] SP_WRITE_MASK = 8'hE0;

    // Alternate feature register: serial port enable
    localparam int ALT_SERIAL_EN = 0;

    // Forced gain codes in mono-to-stereo mode
    localparam logic [3:0] MONO_CENTER_CODE = 4'h0;
    localparam logic [3:0] MONO_SPACE_CODE = 4'h2;

    // Attenuation step of one gain code, in tenths of a dB
    localparam logic [7:0] GAIN_STEP_TENTHS = 8'h0F;

    // Frame index at which the channel status block wraps back to bit 0
    localparam logic [7:0] BLOCK_LAST = 8'hBF;

    // Reset values
    localparam logic [7:0] RESET_BYTE = 8'h00;

    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Pin routing state handed to the pin multiplexers
    typedef struct packed {
        logic serial_on_periph;    // DSP serial pins on periph_data_pins_low
        logic serial_on_joystick;  // DSP serial pins on second joystick
        logic synth_on_periph;     // Synth serial pins on periph_data_pins_high
        logic host_bus_quiet;      // Host data bus not driven on peripheral access
        logic wave_volume_swap;    // Digital volume pair becomes wave volume
    } cpc_route_s;

    // Spatial processing state
    typedef struct packed {
        logic run;                 // 3D path running
        logic mono;                // Mono-to-stereo running
        logic out_from_spatial;    // Serial output from 3D path
        logic [3:0] space_code;    // Effective space code
        logic [3:0] center_code;   // Effective center code
        logic [7:0] space_atten;   // Space attenuation, tenths of dB
        logic [7:0] center_atten;  // Center attenuation, tenths of dB
    } cpc_spatial_s;

endpackage

// ===== sim/cpc_control_chk.sv
// Concurrent checks on the pin routing, gain coding and status stream outputs
`timescale 1ns/1ns
`default_nettype none
module cpc_control_chk (
    // Clock, reset and stream inputs
    input wire logic CLK, input wire logic RST, input wire logic FRAME_TICK,
    input wire logic CONVERTER_BIT, input wire logic SPATIAL_BIT,
    // Stream and pin outputs
    input wire logic BLOCK_START, input wire logic SERIAL_DATA_BIT,
    input wire logic [3:0] PERIPH_LOW_SERIAL_EN, input wire logic [2:0] PERIPH_HIGH_SYNTH_EN,
    input wire logic JOYSTICK_SERIAL_EN, input wire logic HOST_BUS_QUIET,
    input wire logic WAVE_VOLUME_SWAP, input wire cpc_pkg::cpc_spatial_s SPATIAL
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);
    // Source bit one cycle back; cleared in reset so the first edges line up
    logic exp_bit;
    always_ff @(posedge CLK)
        exp_bit <= RST ? 1'h0 : (SPATIAL.out_from_spatial ? SPATIAL_BIT : CONVERTER_BIT);
    a_mono_forced_codes: assert property (SPATIAL.mono |->
        SPATIAL.space_code == 4'h2 && SPATIAL.center_code == 4'h0)
        else $error("mono gain codes not forced");
    a_mono_needs_run: assert property (SPATIAL.mono |-> SPATIAL.run)
        else $error("mono running without 3D enable");
    a_gain_step_atten: assert property (SPATIAL.space_atten == SPATIAL.space_code * 8'h0F
        && SPATIAL.center_atten == SPATIAL.center_code * 8'h0F)
        else $error("attenuation not 1.5 dB per code step");
    // Skipped while the select moves, since the internal copy may lead by a cycle
    a_data_source_sel: assert property ($stable(SPATIAL.out_from_spatial) |->
        SERIAL_DATA_BIT == exp_bit)
        else $error("serial bit from wrong source");
    a_quiet_on_synth: assert property (WAVE_VOLUME_SWAP |-> HOST_BUS_QUIET)
        else $error("host bus driven with synth port on");
    a_synth_pins_swap: assert property (PERIPH_HIGH_SYNTH_EN == {3{WAVE_VOLUME_SWAP}})
        else $error("high pins and volume swap disagree");
    a_serial_pins_excl: assert property (|PERIPH_LOW_SERIAL_EN |->
        PERIPH_LOW_SERIAL_EN == 4'hF && !JOYSTICK_SERIAL_EN && HOST_BUS_QUIET)
        else $error("serial pins on both places");
    a_block_on_tick: assert property ($rose(BLOCK_START) |-> $past(FRAME_TICK))
        else $error("block start rose without a frame tick");
    a_block_level: assert property (!FRAME_TICK |=> $stable(BLOCK_START))
        else $error("block start moved between ticks");
    c_mono: cover property (SPATIAL.mono);
    c_block: cover property ($rose(BLOCK_START));
    c_switch: cover property (PERIPH_LOW_SERIAL_EN == 4'hF && WAVE_VOLUME_SWAP);
endmodule
bind cpc_control cpc_control_chk u_chk (.CLK, .RST, .FRAME_TICK, .CONVERTER_BIT, .SPATIAL_BIT,
    .BLOCK_START, .SERIAL_DATA_BIT, .PERIPH_LOW_SERIAL_EN, .PERIPH_HIGH_SYNTH_EN,
    .JOYSTICK_SERIAL_EN, .HOST_BUS_QUIET, .WAVE_VOLUME_SWAP, .SPATIAL);
`default_nettype wire

// ===== sim/cpc_control_tb_top.sv
// Self-checking testbench for the consumer-out pin control register bank
`timescale 1ns/1ns
`default_nettype none
module cpc_control_tb_top;
    // Driven inputs, all defined at time zero
    logic clk = 1'h0, rst = 1'h1, awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0;
    logic rready = 1'h0, cfg_load = 1'h0, cfg_sw = 1'h0, cfg_syn = 1'h0, tick = 1'h0;
    logic conv = 1'h0, spat = 1'h0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    // Design outputs
    logic awready, wready, bvalid, arready, rvalid, run, fmt, usr, vld, sts, bstart, sdat;
    logic rst_n_pin, mclk_gate, joy, quiet, vswap, sb;
    logic [1:0] bresp, rresp, resp;
    logic [31:0] rdata, rd;
    logic [3:0] low_en, q;
    logic [2:0] high_en;
    cpc_pkg::cpc_spatial_s sp;
    int errors = 0, n_checks = 0;
    // Expected status bits of frames 0..9 for a lower status byte of AA
    localparam logic [9:0] STS_EXP = 10'h22A;
    cpc_control uut (.CLK(clk), .RST(rst), .AWADDR(awaddr), .AWVALID(awvalid),
        .AWREADY(awready), .WDATA(wdata), .WSTRB(4'hF), .WVALID(wvalid), .WREADY(wready),
        .BRESP(bresp), .BVALID(bvalid), .BREADY(bready), .ARADDR(araddr), .ARVALID(arvalid),
        .ARREADY(arready), .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid), .RREADY(rready),
        .CFG_LOAD(cfg_load), .CFG_PORT_SWITCH(cfg_sw), .CFG_SYNTH_ENABLE(cfg_syn),
        .FRAME_TICK(tick), .CONVERTER_BIT(conv), .SPATIAL_BIT(spat), .SERIAL_RUN(run),
        .CONSUMER_FORMAT(fmt), .SUBFRAME_USER(usr), .SUBFRAME_VALID(vld), .SUBFRAME_STATUS(sts),
        .BLOCK_START(bstart), .SERIAL_DATA_BIT(sdat), .PERIPH_RESET_N(rst_n_pin),
        .SYNTH_CLOCK_GATE(mclk_gate), .PERIPH_LOW_SERIAL_EN(low_en),
        .PERIPH_HIGH_SYNTH_EN(high_en), .JOYSTICK_SERIAL_EN(joy), .HOST_BUS_QUIET(quiet),
        .WAVE_VOLUME_SWAP(vswap), .SPATIAL(sp));
    // 20 MHz clock
    initial forever #25 clk = ~clk;
    // Verdict and end of run
    task automatic results;
        if (errors == 0 && n_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // One comparison; mismatches are reported at once
    task automatic chk(input logic [33:0] got, input logic [33:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // Bus write; both halves offered together, then time for the pins to follow
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic aw_ok, w_ok;
        aw_ok = 1'h0;
        w_ok = 1'h0;
        awaddr <= a;
        wdata <= {24'h000000, d};
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        while (!(aw_ok && w_ok))
        begin
            @(posedge clk);
            aw_ok = aw_ok | awready;
            w_ok = w_ok | wready;
            if (aw_ok) awvalid <= 1'h0;
            if (w_ok) wvalid <= 1'h0;
        end
        do @(posedge clk); while (!bvalid);
        resp = bresp;
        bready <= 1'h0;
        repeat (3) @(posedge clk);
    endtask
    // Bus read; an edge passes after the release so ready is never re-driven at once
    task automatic rdr(input logic [7:0] a);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        do
        begin
            @(posedge clk);
            if (arready) arvalid <= 1'h0;
        end
        while (!rvalid);
        rd = rdata;
        resp = rresp;
        rready <= 1'h0;
        @(posedge clk);
    endtask
    // One frame tick pulse, then let the stream registers settle
    task automatic frame;
        tick <= 1'h1;
        @(posedge clk);
        tick <= 1'h0;
        repeat (2) @(posedge clk);
    endtask
    // Whole run is under 3000 cycles, so 40000 cycles means a hang
    initial
    begin
        #2000000;
        errors++;
        results();
    end
    initial
    begin
        repeat (10) @(posedge clk);
        rst <= 1'h0;
        @(posedge clk);
        rdr(cpc_pkg::ADDR_WAVETABLE_PIN);
        chk({rd, rst_n_pin, mclk_gate}, 34'h3);
        // Every wavetable code with serial enable off, then on
        for (int s = 0; s < 2; s++)
            for (int v = 0; v < 16; v++)
            begin
                sb = 1'(s);
                q = 4'(v);
                wr(cpc_pkg::ADDR_ALT_FEATURE, 8'(s));
                wr(cpc_pkg::ADDR_WAVETABLE_PIN, 8'(v));
                chk({run, rst_n_pin, mclk_gate, low_en, joy, high_en, quiet, vswap},
                    {sb, ~q[0], ~q[1], {4{q[2] & sb}}, sb & ~q[2],
                    {3{q[3]}}, |q[3:2], q[3]});
                rdr(cpc_pkg::ADDR_WAVETABLE_PIN);
                chk(rd, 32'(v));
            end
        wr(cpc_pkg::ADDR_ALT_FEATURE, 8'h00);
        wr(cpc_pkg::ADDR_CONSUMER_PORT, 8'hA0);
        chk({fmt, usr, vld}, 3'h2);
        wr(cpc_pkg::ADDR_ALT_FEATURE, 8'h01);
        chk({fmt, usr, vld}, 3'h6);
        wr(cpc_pkg::ADDR_CONSUMER_PORT, 8'h90);
        chk({fmt, usr, vld}, 3'h5);
        // Gain codes, enable and mono forcing
        wr(cpc_pkg::ADDR_SPACE_CENTER, 8'hF8);
        wr(cpc_pkg::ADDR_SPATIAL_CTRL, 8'h80);
        chk({sp.run, sp.mono, sp.space_code, sp.center_code, sp.space_atten, sp.center_atten},
            {2'h2, 24'hF8E178});
        wr(cpc_pkg::ADDR_SPATIAL_CTRL, 8'h40);
        chk({sp.run, sp.mono}, 2'h0);
        wr(cpc_pkg::ADDR_SPATIAL_CTRL, 8'hC0);
        chk({sp.mono, sp.space_code, sp.center_code, sp.space_atten}, 17'h1201E);
        spat <= 1'h1;
        wr(cpc_pkg::ADDR_SPATIAL_CTRL, 8'h20);
        chk(sdat, 1'h1);
        wr(cpc_pkg::ADDR_SPATIAL_CTRL, 8'h00);
        chk(sdat, 1'h0);
        // Status stream; the second restart lands in mid-block
        wr(cpc_pkg::ADDR_LOWER_STATUS, 8'hAA);
        for (int r = 0; r < 2; r++)
        begin
            wr(cpc_pkg::ADDR_CONSUMER_PORT, 8'hC0);
            for (int f = 0; f < 10; f++)
            begin
                frame();
                chk(bstart, f == 0);
                chk(sts, STS_EXP[f]);
            end
        end
        // Unmapped and reserved places
        wr(8'h40, 8'h00);
        chk(resp, 2'h2);
        rdr(8'h40);
        chk({resp, rd}, {2'h2, 32'h0});
        rdr(cpc_pkg::ADDR_RESERVED_CTRL);
        chk(rd, 32'h0);
        // Configuration byte load sets switch and synth enable
        wr(cpc_pkg::ADDR_WAVETABLE_PIN, 8'h00);
        cfg_sw <= 1'h1;
        cfg_syn <= 1'h1;
        cfg_load <= 1'h1;
        @(posedge clk);
        cfg_load <= 1'h0;
        repeat (3) @(posedge clk);
        rdr(cpc_pkg::ADDR_WAVETABLE_PIN);
        chk(rd, 32'hC);
        results();
    end
endmodule
`default_nettype wire
